// ### msc_buf2.sv
// msc_buf2.sv: two-entry byte buffer with valid and ready on both sides
// assumes: one clock; storage keeps its contents across reset
`timescale 1ns/1ps
module msc_buf2 (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // filling side
   input wire logic inValid,
   input wire msc_pkg::msc_byte_t inData,
   output logic inReady,
   // draining side
   output logic outValid,
   output msc_pkg::msc_byte_t outData,
   input wire logic outReady
);
   import msc_pkg::*;

   msc_byte_t mem_reg [2];
   logic wrPtr_reg;
   logic rdPtr_reg;
   logic [1:0] cnt_reg;
   logic [1:0] cnt_next;
   wire push = inValid && inReady;
   wire pop = outValid && outReady;

   // occupancy after this cycle
   assign cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
   assign outData = mem_reg[rdPtr_reg];

   // data storage has no reset so bytes survive a reset pulse [RULE_21]
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem_reg[wrPtr_reg] <= inData;
      end
   end

   // pointers and flags, flags kept as flops so ports come from registers
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wrPtr_reg <= 1'b0;
         rdPtr_reg <= 1'b0;
         cnt_reg <= 2'h0;
         inReady <= 1'b0;
         outValid <= 1'b0;
      end else begin
         wrPtr_reg <= wrPtr_reg ^ push;
         rdPtr_reg <= rdPtr_reg ^ pop;
         cnt_reg <= cnt_next;
         inReady <= (cnt_next != 2'h2);
         outValid <= (cnt_next != 2'h0);
      end
   end
endmodule : msc_buf2

// ### msc_modem_model.sv
// msc_modem_model.sv: remote modem on the line side of the serial block
// assumes: same clock as the block; bench sets carrier, channel 1 and delay
`timescale 1ns/1ps
module msc_modem_model (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // scenario controls
   input wire logic carrierOn,
   input wire logic ch1Clear,
   input wire logic [3:0] answerDelay,
   // line pins, all active low
   input wire logic requestToSendOutCh0N,
   output logic clearToSendInCh0N,
   output logic carrierDetectInCh0N,
   output logic clearToSendInCh1N
);
   logic [3:0] waitCnt_reg;
   // grant clear-to-send some cycles after a request, withdraw at once
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         waitCnt_reg <= 4'h0;
         clearToSendInCh0N <= 1'b1;
      end else if (requestToSendOutCh0N) begin
         waitCnt_reg <= 4'h0;
         clearToSendInCh0N <= 1'b1;
      end else if (waitCnt_reg >= answerDelay) begin
         clearToSendInCh0N <= 1'b0;
      end else begin
         waitCnt_reg <= waitCnt_reg + 4'h1;
      end
   end
   // carrier and channel 1 pins idle high when off
   assign carrierDetectInCh0N = ~carrierOn;
   assign clearToSendInCh1N = ~ch1Clear;
endmodule : msc_modem_model

// ### msc_params.svh
// msc_params.svh: register offsets, field positions and reset values
// assumes: included by the serial modem control module and its bench
`ifndef MSC_PARAMS_SVH
`define MSC_PARAMS_SVH

// i/o space offsets
`define MSC_ADDR_SERIAL_STATUS_CH0 8'h04
`define MSC_ADDR_SERIAL_STATUS_CH1 8'h05
`define MSC_ADDR_RXDATA0 8'h08
`define MSC_ADDR_EXT0 8'h12
`define MSC_ADDR_EXT1 8'h13
`define MSC_ADDR_TC0L 8'h1A
`define MSC_ADDR_TC0H 8'h1B
`define MSC_ADDR_TC1L 8'h1C
`define MSC_ADDR_TC1H 8'h1D
`define MSC_ADDR_MODEM 8'h1E

// extension control fields
`define MSC_EXT_RXINH 7
`define MSC_EXT_DCDDIS 6
`define MSC_EXT_CTSDIS 5
`define MSC_EXT_X1 4
`define MSC_EXT_BRGMODE 3
`define MSC_EXT_BRKDIS 2
`define MSC_EXT_BRKDET 1
`define MSC_EXT_SENDBRK 0
`define MSC_EXT1_RSVD_MASK 8'h9F

// status fields
`define MSC_ST_RXFULL 7
`define MSC_ST_OVERRUN_ERROR_FLAG 6
`define MSC_ST_PERR 5
`define MSC_ST_FERR 4
`define MSC_ST_DCD 2
`define MSC_ST_CTSEN 2
`define MSC_ST_TXEMPTY 1

// modem control register field
`define MSC_MODEM_RTS 0

// reset values
`define MSC_RST_BYTE 8'h00
`define MSC_RST_TC 16'h0000

`endif

// ### msc_pkg.sv
// msc_pkg.sv: types shared by the serial modem control block
// assumes: msc_params.svh is on the include path
package msc_pkg;
   typedef logic [7:0] msc_byte_t;
   typedef logic [15:0] msc_tc_t;
   // error flags in order overrun, parity, framing
   typedef logic [2:0] msc_err_t;
endpackage : msc_pkg

// ### msc_serial_ctrl.sv
// msc_serial_ctrl.sv: modem lines, baud time constants and flag gating
// assumes: cpu i/o strobes on clk_sys, shift logic and dma outside
//
// Function
// [RULE_01] break feature on when extension bit is 0, off when 1
// [RULE_02] channel 0 time constant bytes at 1AH and 1BH, reset zero
// [RULE_03] channel 1 time constant bytes at 1CH and 1DH, reset zero
// [RULE_04] baud mode bit makes time constant pair a 16-bit rate counter
// [RULE_05] channel 0 has clear-to-send, carrier-detect inputs and request-to-send out
// [RULE_06] channel 1 clear-to-send shares pin with clocked serial receive data
// [RULE_07] channel 0 clear-to-send high forces transmit-empty flag to 0
// [RULE_08] channel 0 clear-to-send low lets transmit-empty follow data register
// [RULE_09] clear-to-send only masks the flag, never stops the transmitter
// [RULE_10] carrier-detect high forces receive-full flag to 0
// [RULE_11] carrier-detect high also forces parity, framing, overrun flags to 0
// [RULE_12] flags stay suppressed after carrier returns until status is read
// [RULE_13] that first read re-enables flags yet still shows carrier bit 1
// [RULE_14] software reads status twice to see carrier bit cleared
// [RULE_15] request-to-send is a plain output bit with no side effects
// [RULE_16] shared pin acts as clear-to-send only when enable bit is 1
// [RULE_17] enabled channel 1 clear-to-send gates its transmit-empty likewise
// [RULE_18] receive-full and transmit-empty flags feed dma channel 0 requests
// [RULE_19] reset brings status and control registers to their reset values
// [RULE_20] reset halts receive and transmit activity on both channels
// [RULE_21] reset leaves transmit and receive data contents unchanged
`timescale 1ns/1ps
`include "msc_params.svh"
module msc_serial_ctrl (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // cpu i/o space
   input wire msc_pkg::msc_byte_t ioAddr,
   input wire msc_pkg::msc_byte_t ioWrData,
   input wire logic ioWr,
   input wire logic ioRd,
   output msc_pkg::msc_byte_t ioRdData,
   // modem pins
   input wire logic clearToSendInCh0N,
   input wire logic carrierDetectInCh0N,
   input wire logic clearToSendInCh1N,
   output logic requestToSendOutCh0N,
   output logic clockedSerialRxData,
   // shift logic side
   input wire logic [1:0] txDataFull,
   input wire logic rxDataFullCh1,
   input wire msc_pkg::msc_err_t rxErrIn0,
   input wire msc_pkg::msc_err_t rxErrIn1,
   input wire logic [1:0] breakDetected,
   input wire logic [1:0] fixedTick,
   input wire logic rxByteValid,
   input wire msc_pkg::msc_byte_t rxByteData,
   output logic rxByteReady,
   // gated flags and dma requests
   output logic [1:0] txRegisterEmptyFlag,
   output logic [1:0] rxRegisterFullFlag,
   output msc_pkg::msc_err_t errFlagsCh0,
   output msc_pkg::msc_err_t errFlagsCh1,
   output logic [1:0] dmaTxReq,
   output logic [1:0] dmaRxReq,
   // controls to the shift logic
   output logic serialRun,
   output logic [1:0] baudTick,
   output logic [1:0] breakFeatureEn,
   output logic [1:0] sendBreak,
   output logic [1:0] bitClockX1,
   output logic [1:0] rxIntInhibitOff
);
   import msc_pkg::*;

   // control and status storage
   msc_byte_t tcLo_reg [2];
   msc_byte_t tcHi_reg [2];
   msc_byte_t ext_reg [2];
   logic cts1Enable_reg;
   logic suppress_reg;
   logic [2:0] pinMeta_reg;
   logic [2:0] pinSync_reg;

   // pins are asynchronous, two flops before any use [RULE_05] [RULE_06]
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pinMeta_reg <= 3'h7;
         pinSync_reg <= 3'h7;
      end else begin
         pinMeta_reg <= {clearToSendInCh1N, carrierDetectInCh0N, clearToSendInCh0N};
         pinSync_reg <= pinMeta_reg;
      end
   end

   wire ctsHighCh0 = pinSync_reg[0];
   wire dcdHighCh0 = pinSync_reg[1];
   wire sharedPinHigh = pinSync_reg[2];

   // address decode
   wire selStat0 = (ioAddr == `MSC_ADDR_SERIAL_STATUS_CH0);
   wire selStat1 = (ioAddr == `MSC_ADDR_SERIAL_STATUS_CH1);
   wire selRxData0 = (ioAddr == `MSC_ADDR_RXDATA0);
   wire selModem = (ioAddr == `MSC_ADDR_MODEM);
   wire [1:0] selExt = {ioAddr == `MSC_ADDR_EXT1, ioAddr == `MSC_ADDR_EXT0};
   wire [1:0] selTcLo = {ioAddr == `MSC_ADDR_TC1L, ioAddr == `MSC_ADDR_TC0L};
   wire [1:0] selTcHi = {ioAddr == `MSC_ADDR_TC1H, ioAddr == `MSC_ADDR_TC0H};
   wire stat0Rd = ioRd && selStat0;
   wire rxData0Rd = ioRd && selRxData0;

   // receive bytes of channel 0 wait in the buffer; a slow cpu stalls the shifter
   logic rxBufValid;
   msc_byte_t rxBufData;
   msc_buf2 u_rxBuf (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .inValid(rxByteValid),
      .inData(rxByteData),
      .inReady(rxByteReady),
      .outValid(rxBufValid),
      .outData(rxBufData),
      .outReady(rxData0Rd)
   );

   // per channel time constant and extension registers [RULE_19]
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_chan
         logic [15:0] cnt_reg;
         logic tick_reg;
         wire msc_tc_t tc = {tcHi_reg[ch], tcLo_reg[ch]};
         wire brgMode = ext_reg[ch][`MSC_EXT_BRGMODE];

         // byte registers, written whole [RULE_02] [RULE_03]
         always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               tcLo_reg[ch] <= `MSC_RST_BYTE;
               tcHi_reg[ch] <= `MSC_RST_BYTE;
               ext_reg[ch] <= `MSC_RST_BYTE;
            end else if (ioWr) begin
               if (selTcLo[ch]) tcLo_reg[ch] <= ioWrData;
               if (selTcHi[ch]) tcHi_reg[ch] <= ioWrData;
               if (selExt[ch]) ext_reg[ch] <= ioWrData;
            end
         end

         // 16-bit rate counter replaces the fixed chain in baud mode [RULE_04]
         always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               cnt_reg <= `MSC_RST_TC;
               tick_reg <= 1'b0;
            end else if (!brgMode) begin
               cnt_reg <= tc;
               tick_reg <= fixedTick[ch];
            end else if (cnt_reg == 16'h0000) begin
               cnt_reg <= tc;
               tick_reg <= 1'b1;
            end else begin
               cnt_reg <= cnt_reg - 16'h0001;
               tick_reg <= 1'b0;
            end
         end
         // ticks stop while reset is held, which halts both shifters [RULE_20]
         assign baudTick[ch] = tick_reg;
      end
   endgenerate

   // write-side flops of modem control and channel 1 enable
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         requestToSendOutCh0N <= 1'b1;
         cts1Enable_reg <= 1'b0;
      end else if (ioWr) begin
         // touches nothing else in the block [RULE_15]
         if (selModem) requestToSendOutCh0N <= ~ioWrData[`MSC_MODEM_RTS];
         if (selStat1) cts1Enable_reg <= ioWrData[`MSC_ST_CTSEN];
      end
   end

   // carrier suppression: set while carrier high, set wins over read clear
   wire dcdGateOn = !ext_reg[0][`MSC_EXT_DCDDIS];
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         suppress_reg <= 1'b0;
      end else if (dcdHighCh0) begin
         suppress_reg <= 1'b1; // [RULE_10] [RULE_11]
      end else if (stat0Rd) begin
         suppress_reg <= 1'b0; // [RULE_12] [RULE_13]
      end
   end

   // flag gating; clear-to-send only masks flags, transmitter keeps running [RULE_09]
   wire ctsMask0 = ctsHighCh0 && !ext_reg[0][`MSC_EXT_CTSDIS]; // [RULE_07] [RULE_08]
   wire ctsMask1 = cts1Enable_reg && sharedPinHigh; // [RULE_16] [RULE_17]
   wire rxMask0 = (suppress_reg || dcdHighCh0) && dcdGateOn; // [RULE_10] [RULE_12]
   wire [1:0] txEmptyNext = {!txDataFull[1] && !ctsMask1, !txDataFull[0] && !ctsMask0};
   wire [1:0] rxFullNext = {rxDataFullCh1, rxBufValid && !rxMask0};
   wire msc_err_t err0Next = rxMask0 ? 3'h0 : rxErrIn0; // [RULE_11]

   // registered flags, dma requests and control outputs
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         txRegisterEmptyFlag <= 2'h0;
         rxRegisterFullFlag <= 2'h0;
         errFlagsCh0 <= 3'h0;
         errFlagsCh1 <= 3'h0;
         dmaTxReq <= 2'h0;
         dmaRxReq <= 2'h0;
         serialRun <= 1'b0; // [RULE_20]
         clockedSerialRxData <= 1'b1;
      end else begin
         txRegisterEmptyFlag <= txEmptyNext;
         rxRegisterFullFlag <= rxFullNext;
         errFlagsCh0 <= err0Next;
         errFlagsCh1 <= rxErrIn1;
         dmaTxReq <= txEmptyNext; // [RULE_18]
         dmaRxReq <= rxFullNext; // [RULE_18]
         serialRun <= 1'b1;
         clockedSerialRxData <= sharedPinHigh; // [RULE_06]
      end
   end

   // extension bits steer the shift logic; break feature is active low [RULE_01]
   assign breakFeatureEn = {!ext_reg[1][`MSC_EXT_BRKDIS], !ext_reg[0][`MSC_EXT_BRKDIS]};
   assign sendBreak = {ext_reg[1][`MSC_EXT_SENDBRK], ext_reg[0][`MSC_EXT_SENDBRK]};
   assign bitClockX1 = {ext_reg[1][`MSC_EXT_X1], ext_reg[0][`MSC_EXT_X1]};
   assign rxIntInhibitOff = {ext_reg[1][`MSC_EXT_RXINH], ext_reg[0][`MSC_EXT_RXINH]};

   // read values; status shows the latched carrier so the first read gives 1
   wire msc_byte_t stat0Val = {rxFullNext[0], err0Next, 1'b0,
      suppress_reg || dcdHighCh0, txEmptyNext[0], 1'b0}; // [RULE_13]
   wire msc_byte_t stat1Val = {rxFullNext[1], rxErrIn1, 1'b0,
      cts1Enable_reg, txEmptyNext[1], 1'b0};
   wire msc_byte_t ext0Val = {ext_reg[0][7:2], breakDetected[0], ext_reg[0][0]};
   wire msc_byte_t ext1Val = {ext_reg[1][7:2], breakDetected[1], ext_reg[1][0]}
      & `MSC_EXT1_RSVD_MASK;
   wire msc_byte_t rdMux =
      selStat0 ? stat0Val :
      selStat1 ? stat1Val :
      selRxData0 ? rxBufData :
      selExt[0] ? ext0Val :
      selExt[1] ? ext1Val :
      selTcLo[0] ? tcLo_reg[0] :
      selTcHi[0] ? tcHi_reg[0] :
      selTcLo[1] ? tcLo_reg[1] :
      selTcHi[1] ? tcHi_reg[1] :
      selModem ? {7'h00, ~requestToSendOutCh0N} : 8'h00;

   // read data is captured on the read strobe and held until the next read
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ioRdData <= `MSC_RST_BYTE;
      end else if (ioRd) begin
         ioRdData <= rdMux;
      end
   end

   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   property p_ctsMask;
      (ctsHighCh0 && !ext_reg[0][`MSC_EXT_CTSDIS]) |=> !txRegisterEmptyFlag[0];
   endproperty
   a_ctsMask: assert property (p_ctsMask) else $error("tx empty not masked"); // [RULE_07]

   property p_ctsFollow;
      (!ctsHighCh0 && !txDataFull[0]) |=> txRegisterEmptyFlag[0];
   endproperty
   a_ctsFollow: assert property (p_ctsFollow) else $error("tx empty lost"); // [RULE_08]

   property p_dcdRx;
      (dcdHighCh0 && dcdGateOn) |=> !rxRegisterFullFlag[0];
   endproperty
   a_dcdRx: assert property (p_dcdRx) else $error("rx full not masked"); // [RULE_10]

   property p_dcdErr;
      (dcdHighCh0 && dcdGateOn) |=> (errFlagsCh0 == 3'h0);
   endproperty
   a_dcdErr: assert property (p_dcdErr) else $error("error flags not masked"); // [RULE_11]

   sequence s_carrierBack;
      suppress_reg && !dcdHighCh0 && !stat0Rd;
   endsequence
   property p_holdSuppress;
      s_carrierBack |=> suppress_reg;
   endproperty
   a_holdSuppress: assert property (p_holdSuppress) else $error("suppress dropped"); // [RULE_12]

   sequence s_firstRead;
      suppress_reg && !dcdHighCh0 && stat0Rd;
   endsequence
   property p_firstRead;
      s_firstRead |=> (ioRdData[`MSC_ST_DCD] && !suppress_reg);
   endproperty
   a_firstRead: assert property (p_firstRead) else $error("first read wrong"); // [RULE_13]

   property p_rtsWrite;
      (ioWr && selModem) |=> (requestToSendOutCh0N == !$past(ioWrData[`MSC_MODEM_RTS]))
         && $stable(ext_reg[0]);
   endproperty
   a_rtsWrite: assert property (p_rtsWrite) else $error("rts write wrong"); // [RULE_15]

   property p_cts1Off;
      !cts1Enable_reg |=> (txRegisterEmptyFlag[1] == !$past(txDataFull[1]));
   endproperty
   a_cts1Off: assert property (p_cts1Off) else $error("clear_to_send_in_ch1 gates when off"); // [RULE_16]

   property p_tcWrite;
      (ioWr && selTcLo[0]) |=> (tcLo_reg[0] == $past(ioWrData));
   endproperty
   a_tcWrite: assert property (p_tcWrite) else $error("tc low not written"); // [RULE_02]

   property p_brgReload;
      (ext_reg[0][`MSC_EXT_BRGMODE] && baudTick[0] && !(ioWr && (selTcLo[0] || selTcHi[0])))
         |=> (g_chan[0].cnt_reg == $past(g_chan[0].cnt_reg) - 16'h0001)
         || $past(g_chan[0].cnt_reg) == 16'h0000 || !ext_reg[0][`MSC_EXT_BRGMODE];
   endproperty
   a_brgReload: assert property (p_brgReload) else $error("baud counter stuck"); // [RULE_04]

   property p_dmaTx;
      (!txDataFull[0] && !ctsHighCh0) |=> dmaTxReq[0];
   endproperty
   a_dmaTx: assert property (p_dmaTx) else $error("dma tx request missing"); // [RULE_18]

   property p_dmaRx;
      (rxBufValid && !suppress_reg && !dcdHighCh0) |=> (dmaRxReq[0] && rxRegisterFullFlag[0]);
   endproperty
   a_dmaRx: assert property (p_dmaRx) else $error("dma rx request missing"); // [RULE_18]

   property p_cts1Mask;
      (cts1Enable_reg && sharedPinHigh) |=> !txRegisterEmptyFlag[1];
   endproperty
   a_cts1Mask: assert property (p_cts1Mask) else $error("ch1 tx empty not masked"); // [RULE_17]

   // once the latch is clear a status read must show the carrier bit low
   sequence s_clearedRead;
      !suppress_reg && !dcdHighCh0 && stat0Rd;
   endsequence
   property p_secondRead;
      s_clearedRead |=> !ioRdData[`MSC_ST_DCD];
   endproperty
   a_secondRead: assert property (p_secondRead) else $error("carrier bit stuck"); // [RULE_14]

   property p_ext1Rsvd;
      (ioRd && selExt[1]) |=> (ioRdData[6:5] == 2'h0);
   endproperty
   a_ext1Rsvd: assert property (p_ext1Rsvd) else $error("reserved bits read set"); // [RULE_19]

   property p_break;
      (ioWr && selExt[1]) |=> (breakFeatureEn[1] == !$past(ioWrData[`MSC_EXT_BRKDIS]));
   endproperty
   a_break: assert property (p_break) else $error("break enable wrong"); // [RULE_01]
endmodule : msc_serial_ctrl

// ### tb.sv
// tb.sv: self-checking bench for the serial modem control block
// assumes: modem model on the pins; the bench plays cpu and shift logic
`timescale 1ns/1ps
`include "msc_params.svh"
module tb;
   import msc_pkg::*;
   logic clk_sys, rst_n, ioWr, ioRd, rxDataFullCh1, rxByteValid, rxByteReady;
   logic cts0N, dcdN, cts1N, rtsN, clkRx, serialRun, carrierOn, ch1Clear;
   logic [3:0] answerDelay;
   msc_byte_t ioAddr, ioWrData, ioRdData, rxByteData, d;
   msc_err_t rxErrIn0, rxErrIn1, errFlagsCh0, errFlagsCh1;
   logic [1:0] txDataFull, breakDetected, fixedTick, txEmpty, rxFull, dmaTxReq, dmaRxReq;
   logic [1:0] baudTick, breakFeatureEn, sendBreak, bitClockX1, rxIntInhibitOff;
   int num_errors = 0;
   int checked = 0;
   int cycles = 0;
   msc_serial_ctrl dut (.clk_sys(clk_sys), .rst_n(rst_n), .ioAddr(ioAddr),
      .ioWrData(ioWrData), .ioWr(ioWr), .ioRd(ioRd), .ioRdData(ioRdData),
      .clearToSendInCh0N(cts0N), .carrierDetectInCh0N(dcdN), .clearToSendInCh1N(cts1N),
      .requestToSendOutCh0N(rtsN), .clockedSerialRxData(clkRx), .txDataFull(txDataFull),
      .rxDataFullCh1(rxDataFullCh1), .rxErrIn0(rxErrIn0), .rxErrIn1(rxErrIn1),
      .breakDetected(breakDetected), .fixedTick(fixedTick), .rxByteValid(rxByteValid),
      .rxByteData(rxByteData), .rxByteReady(rxByteReady), .txRegisterEmptyFlag(txEmpty),
      .rxRegisterFullFlag(rxFull), .errFlagsCh0(errFlagsCh0), .errFlagsCh1(errFlagsCh1),
      .dmaTxReq(dmaTxReq), .dmaRxReq(dmaRxReq), .serialRun(serialRun), .baudTick(baudTick),
      .breakFeatureEn(breakFeatureEn), .sendBreak(sendBreak), .bitClockX1(bitClockX1),
      .rxIntInhibitOff(rxIntInhibitOff));
   msc_modem_model modem (.clk_sys(clk_sys), .rst_n(rst_n), .carrierOn(carrierOn),
      .ch1Clear(ch1Clear), .answerDelay(answerDelay), .requestToSendOutCh0N(rtsN),
      .clearToSendInCh0N(cts0N), .carrierDetectInCh0N(dcdN), .clearToSendInCh1N(cts1N));
   // 250 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic complete_run();
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : complete_run
   // one strobe cycle per access, raised and lowered at falling edges
   task automatic ioWrite(input msc_byte_t a, input msc_byte_t v);
      @(negedge clk_sys);
      ioAddr = a;
      ioWrData = v;
      ioWr = 1'b1;
      @(negedge clk_sys);
      ioWr = 1'b0;
   endtask : ioWrite
   task automatic ioRead(input msc_byte_t a, output msc_byte_t v);
      @(negedge clk_sys);
      ioAddr = a;
      ioRd = 1'b1;
      @(negedge clk_sys);
      ioRd = 1'b0;
      v = ioRdData;
   endtask : ioRead
   // hold the byte until an edge sees ready, then scramble the data lines
   task automatic pushByte(input msc_byte_t b);
      @(negedge clk_sys);
      rxByteValid = 1'b1;
      rxByteData = b;
      for (int i = 0; i < 50 && rxByteReady !== 1'b1; i++) @(negedge clk_sys);
      @(negedge clk_sys);
      rxByteValid = 1'b0;
      rxByteData = ~b;
   endtask : pushByte
   // cycles between two successive baud ticks of one channel
   task automatic tickGap(input int ch, output int n);
      for (int i = 0; i < 600 && baudTick[ch] !== 1'b1; i++) @(negedge clk_sys);
      @(negedge clk_sys);
      n = 1;
      while (n < 600 && baudTick[ch] !== 1'b1) begin
         @(negedge clk_sys);
         n++;
      end
   endtask : tickGap
   task automatic resetValues();
      msc_byte_t addrs[7] = '{8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h12, 8'h13, 8'h3F};
      foreach (addrs[i]) begin
         ioRead(addrs[i], d);
         check("reset byte", d, 16'h0000);
      end
      check("break enable", breakFeatureEn, 16'h0003);
      check("run", serialRun, 16'h0001);
      check("rts pin", rtsN, 16'h0001);
   endtask : resetValues
   task automatic regAccess();
      msc_byte_t addrs[4] = '{8'h1A, 8'h1B, 8'h1C, 8'h1D};
      msc_byte_t vals[4] = '{8'h5A, 8'hA5, 8'h3C, 8'hC3};
      foreach (addrs[i]) ioWrite(addrs[i], vals[i]);
      foreach (addrs[i]) begin
         ioRead(addrs[i], d);
         check("time constant", d, {8'h00, vals[i]});
      end
      ioWrite(8'h13, 8'hFF);
      ioRead(8'h13, d);
      check("ext1 reserved", d, 16'h009D);
      check("ext1 outs", {sendBreak[1], bitClockX1[1], rxIntInhibitOff[1]}, 16'h0007);
      ioWrite(8'h12, 8'h04);
      check("break enable off", breakFeatureEn, 16'h0000);
      ioWrite(8'h12, 8'h00);
      ioWrite(8'h13, 8'h00);
      breakDetected = 2'b01;
      ioRead(8'h12, d);
      check("break detect", d, 16'h0002);
      check("break enable on", breakFeatureEn, 16'h0003);
      breakDetected = 2'b00;
   endtask : regAccess
   task automatic baudRate();
      int n;
      @(negedge clk_sys);
      fixedTick = 2'b11;
      @(negedge clk_sys);
      fixedTick = 2'b00;
      check("fixed tick", baudTick, 16'h0003);
      ioWrite(8'h1A, 8'h02);
      ioWrite(8'h1B, 8'h01);
      ioWrite(8'h1C, 8'h03);
      ioWrite(8'h1D, 8'h00);
      ioWrite(8'h12, 8'h08);
      ioWrite(8'h13, 8'h08);
      tickGap(0, n);
      check("ch0 baud gap", n[15:0], 16'h0103);
      tickGap(1, n);
      check("ch1 baud gap", n[15:0], 16'h0004);
      ioWrite(8'h12, 8'h00);
      ioWrite(8'h13, 8'h00);
   endtask : baudRate
   task automatic clearToSend0(input logic [3:0] delay);
      answerDelay = delay;
      txDataFull = 2'b00;
      check("tx empty masked", txEmpty[0], 16'h0000);
      ioWrite(8'h1E, 8'h01);
      check("rts low", rtsN, 16'h0000);
      repeat (delay + 6) @(negedge clk_sys);
      check("tx empty", txEmpty[0], 16'h0001);
      check("dma tx", dmaTxReq[0], 16'h0001);
      ioRead(8'h04, d);
      check("status0", d, 16'h0006);
      ioRead(8'h1A, d);
      check("rts side effect", d, 16'h0002);
      txDataFull = 2'b01;
      repeat (2) @(negedge clk_sys);
      check("tx full", txEmpty[0], 16'h0000);
      txDataFull = 2'b00;
      ioWrite(8'h1E, 8'h00);
      repeat (5) @(negedge clk_sys);
      check("tx empty masked", {dmaTxReq[0], txEmpty[0]}, 16'h0000);
      check("still running", serialRun, 16'h0001);
   endtask : clearToSend0
   task automatic carrierDetect();
      rxErrIn0 = 3'b111;
      pushByte(8'hA5);
      pushByte(8'h5A);
      repeat (2) @(negedge clk_sys);
      check("buffer full", rxByteReady, 16'h0000);
      check("rx full masked", rxFull[0], 16'h0000);
      check("errors masked", errFlagsCh0, 16'h0000);
      ioRead(8'h04, d);
      check("status0 carrier off", d, 16'h0004);
      carrierOn = 1'b1;
      repeat (6) @(negedge clk_sys);
      check("still masked", {rxFull[0], errFlagsCh0}, 16'h0000);
      ioRead(8'h04, d);
      check("first read carrier", d[2], 16'h0001);
      repeat (3) @(negedge clk_sys);
      check("flags back", {dmaRxReq[0], rxFull[0], errFlagsCh0}, 16'h001F);
      ioRead(8'h04, d);
      check("second read", d, 16'h00F0);
      rxErrIn0 = 3'b000;
      ioRead(8'h08, d);
      check("rx byte 1", d, 16'h00A5);
      ioRead(8'h08, d);
      check("rx byte 2", d, 16'h005A);
      repeat (3) @(negedge clk_sys);
      check("drained", {rxByteReady, rxFull[0]}, 16'h0002);
   endtask : carrierDetect
   task automatic clearToSend1();
      check("ungated ch1", {clkRx, txEmpty[1]}, 16'h0003);
      ioWrite(8'h05, 8'h04);
      repeat (4) @(negedge clk_sys);
      check("ch1 masked", txEmpty[1], 16'h0000);
      ioRead(8'h05, d);
      check("status1", d, 16'h0004);
      ch1Clear = 1'b1;
      repeat (4) @(negedge clk_sys);
      check("ch1 clear", {clkRx, dmaTxReq[1], txEmpty[1]}, 16'h0003);
      rxDataFullCh1 = 1'b1;
      rxErrIn1 = 3'b101;
      repeat (2) @(negedge clk_sys);
      check("ch1 rx", {dmaRxReq[1], rxFull[1], errFlagsCh1}, 16'h001D);
      rxDataFullCh1 = 1'b0;
      rxErrIn1 = 3'b000;
   endtask : clearToSend1
   task automatic midReset();
      ioWrite(8'h1C, 8'h77);
      ioWrite(8'h1E, 8'h01);
      @(negedge clk_sys);
      rst_n = 1'b0;
      #1;
      check("halted", {serialRun, rtsN, txEmpty}, 16'h0004);
      repeat (3) @(negedge clk_sys);
      rst_n = 1'b1;
      ioRead(8'h1C, d);
      check("tc after reset", d, 16'h0000);
      ioRead(8'h1E, d);
      check("modem after reset", d, 16'h0000);
      ioRead(8'h08, d);
      check("rx data kept", d, 16'h00A5);
   endtask : midReset
   // hang guard, far above the several hundred cycles the run needs
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         complete_run();
      end
   end
   initial begin
      rst_n = 1'b0;
      {ioWr, ioRd, rxDataFullCh1, rxByteValid, carrierOn, ch1Clear} = 6'h00;
      {ioAddr, ioWrData, rxByteData} = 24'h000000;
      {rxErrIn0, rxErrIn1} = 6'h00;
      {txDataFull, breakDetected, fixedTick} = 6'h00;
      answerDelay = 4'h0;
      repeat (20) @(negedge clk_sys);
      rst_n = 1'b1;
      resetValues();
      regAccess();
      baudRate();
      clearToSend0(4'h0);
      clearToSend0(4'h9);
      carrierDetect();
      clearToSend1();
      midReset();
      complete_run();
   end
endmodule : tb
